// file: src/mspp_defines.svh
// register offsets, field codes and reset values of the paired pulse timer
// assumes a 32-bit apb bus with byte addresses on word boundaries
`ifndef MSPP_DEFINES_SVH
`define MSPP_DEFINES_SVH
`define MSPP_OFS_UNIT_CTRL 8'h00
`define MSPP_OFS_MODE_CFG 8'h04
`define MSPP_OFS_PERIOD 8'h08
`define MSPP_OFS_DUTY 8'h0c
`define MSPP_OFS_MCOUNT 8'h10
`define MSPP_OFS_SCOUNT 8'h14
`define MSPP_OFS_TRIGGER 8'h18
`define MSPP_OFS_OUT_CTRL 8'h1c
`define MSPP_OFS_STATUS 8'h20
`define MSPP_OFS_PRESCALE 8'h24
`define MSPP_MD_INTERVAL 4'h0
`define MSPP_MD_ONE_COUNT 4'h8
`define MSPP_STS_SOFT 3'h0
`define MSPP_STS_EDGE 3'h1
`define MSPP_CKS_ZERO 2'h0
`define MSPP_CKS_ONE 2'h2
`define MSPP_CIS_FALL 2'h0
`define MSPP_CIS_RISE 2'h1
`define MSPP_CIS_BOTH 2'h2
`define MSPP_MASTER_CH0 1'h0
`define MSPP_SLAVE_CH3 2'h3
`define MSPP_MODE_CFG_RST 16'h0000
`define MSPP_PRESCALE_RST 8'h00
`endif

// file: src/mspp_pkg.sv
// types of the paired pulse timer: channel mode word and master state
// assumes the constants header for codes and offsets
package mspp_pkg;
   typedef struct packed {
      logic [1:0] cks;
      logic rsv_hi;
      logic ccs;
      logic master_sel;
      logic [2:0] sts;
      logic edge_select_hi;
      logic edge_select_lo;
      logic [1:0] rsv_lo;
      logic [3:0] md;
   } mspp_mode_cfg_s;
   typedef enum logic [1:0] {
      MST_IDLE,
      MST_ARMED,
      MST_WAIT,
      MST_COUNT
   } mspp_mst_state_e;
endpackage : mspp_pkg

// file: src/mspp_top.sv
// paired master/slave pulse timer with apb register access
// assumes a synchronous trigger input and an apb master on clk_sys
// Summary of operation
// - period is period data plus one ticks
// - zero duty keeps output inactive
// - duty at least period plus one: full
// - pwm start: irq, load, count down
// - master at zero: irq, reload, continue
// - reload repeats until master stop written
// - slave loads duty on master irq
// - slave at zero: irq, stop, wait
// - output active one tick after irq
// - trigger bits clear themselves
// - one-shot start: run bits, wait trigger
// - one-shot: count, irq, wait trigger
// - count registers readable at all times
// - stop freezes counters, holds output
// - output disabled: pin shows software bit
// - unit disable resets everything, port mode
// - master 0 or 2, pairing limits
// - pwm master is software-started interval
// - clock code 00 or 10 selects prescaler
// - slave one-count, triggered by master irq
// - polarity bit: 0 high, 1 low active
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "mspp_defines.svh"
module mspp_top #(
   parameter int CW = 16
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_input_pin,
   output logic pulse_pin_o,
   output logic pulse_pin_oe_n,
   output logic master_done_irq,
   output logic slave_done_irq
);
   // ==========================================================
   // apb slave
   logic apb_wr, apb_rd, acc;
   logic unit_clock_enable_r, master_ch_r;
   logic [1:0] slave_ch_r;
   mspp_pkg::mspp_mode_cfg_s mode_r;
   logic [CW-1:0] period_data_reg_r, duty_data_reg_r;
   logic [CW-1:0] master_count_reg_r, slave_count_reg_r;
   logic [7:0] prescaler_select_reg_r;
   logic pulse_output_r, pulse_output_enable_r, pulse_polarity_r, pulse_output_mode_r;
   logic master_run_status_r, slave_run_status_r, slave_busy_r, slave_act_r;
   mspp_pkg::mspp_mst_state_e mst_r;
   logic [31:0] rd_nxt;
   logic hit;

   assign acc = psel & penable & pready;
   assign apb_wr = acc & pwrite;
   assign apb_rd = acc & ~pwrite;

   // one wait state: answer at the second access edge
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= rd_nxt;
         end
      end
   end

   always_comb begin
      hit = 1'b1;
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `MSPP_OFS_UNIT_CTRL: rd_nxt = {28'h0000000, slave_ch_r, master_ch_r, unit_clock_enable_r};
         `MSPP_OFS_MODE_CFG: rd_nxt = {16'h0000, mode_r};
         `MSPP_OFS_PERIOD: rd_nxt = 32'(period_data_reg_r);
         `MSPP_OFS_DUTY: rd_nxt = 32'(duty_data_reg_r);
         `MSPP_OFS_MCOUNT: rd_nxt = 32'(master_count_reg_r);
         `MSPP_OFS_SCOUNT: rd_nxt = 32'(slave_count_reg_r);
         `MSPP_OFS_TRIGGER: rd_nxt = 32'h0000_0000;
         `MSPP_OFS_OUT_CTRL: rd_nxt = {28'h0000000, pulse_output_mode_r, pulse_polarity_r,
                                       pulse_output_enable_r, pulse_output_r};
         `MSPP_OFS_STATUS: rd_nxt = {28'h0000000, slave_act_r, slave_busy_r,
                                     slave_run_status_r, master_run_status_r};
         `MSPP_OFS_PRESCALE: rd_nxt = {24'h000000, prescaler_select_reg_r};
         default: hit = 1'b0;
      endcase
   end

   logic wr_unit, wr_mode, wr_per, wr_duty, wr_trig, wr_out, wr_pre;
   assign wr_unit = apb_wr & (paddr == `MSPP_OFS_UNIT_CTRL);
   assign wr_mode = apb_wr & (paddr == `MSPP_OFS_MODE_CFG);
   assign wr_per = apb_wr & (paddr == `MSPP_OFS_PERIOD);
   assign wr_duty = apb_wr & (paddr == `MSPP_OFS_DUTY);
   assign wr_trig = apb_wr & (paddr == `MSPP_OFS_TRIGGER);
   assign wr_out = apb_wr & (paddr == `MSPP_OFS_OUT_CTRL);
   assign wr_pre = apb_wr & (paddr == `MSPP_OFS_PRESCALE);

   // ==========================================================
   // unit enable and configuration
   logic unit_off;
   assign unit_off = ~unit_clock_enable_r;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         unit_clock_enable_r <= 1'b0;
      end else if (wr_unit) begin
         unit_clock_enable_r <= pwdata[0];
      end
   end

   // channel registers reset while unit is off
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r <= `MSPP_MODE_CFG_RST;
         period_data_reg_r <= '0;
         duty_data_reg_r <= '0;
         prescaler_select_reg_r <= `MSPP_PRESCALE_RST;
         master_ch_r <= `MSPP_MASTER_CH0;
         slave_ch_r <= 2'h1;
      end else if (unit_off) begin
         mode_r <= `MSPP_MODE_CFG_RST;
         period_data_reg_r <= '0;
         duty_data_reg_r <= '0;
         prescaler_select_reg_r <= `MSPP_PRESCALE_RST;
         master_ch_r <= `MSPP_MASTER_CH0;
         slave_ch_r <= 2'h1;
         if (wr_unit) begin
            master_ch_r <= pwdata[1];
            slave_ch_r <= pwdata[3:2];
         end
      end else begin
         if (wr_mode) mode_r <= pwdata[15:0];
         if (wr_per) period_data_reg_r <= pwdata[CW-1:0];
         if (wr_duty) duty_data_reg_r <= pwdata[CW-1:0];
         if (wr_pre) prescaler_select_reg_r <= pwdata[7:0];
         if (wr_unit) begin
            master_ch_r <= pwdata[1];
            slave_ch_r <= pwdata[3:2];
         end
      end
   end

   // ==========================================================
   // prescaler: two divided enables, one picked as count tick
   logic [15:0] pre_cnt_r;
   logic [15:0] mask0, mask1;
   logic tick;
   assign mask0 = 16'((17'h1 << prescaler_select_reg_r[3:0]) - 17'h1);
   assign mask1 = 16'((17'h1 << prescaler_select_reg_r[7:4]) - 17'h1);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) pre_cnt_r <= 16'h0000;
      else if (unit_off) pre_cnt_r <= 16'h0000;
      else pre_cnt_r <= pre_cnt_r + 16'h0001;
   end

   assign tick = unit_clock_enable_r & ((mode_r.cks == `MSPP_CKS_ONE) ?
                 ((pre_cnt_r & mask1) == 16'h0000) : ((pre_cnt_r & mask0) == 16'h0000));

   // ==========================================================
   // triggers and edge detection
   logic start_m, start_s, stop_m, stop_s, pair_ok, is_pwm, is_oneshot;
   logic trig_prev_r, edge_hit, trig_pend_r;
   assign start_m = wr_trig & pwdata[0];
   assign start_s = wr_trig & pwdata[1];
   assign stop_m = wr_trig & pwdata[2];
   assign stop_s = wr_trig & pwdata[3];
   assign pair_ok = (slave_ch_r != 2'h0) &&
                    ((master_ch_r == `MSPP_MASTER_CH0) || (slave_ch_r == `MSPP_SLAVE_CH3));
   assign is_pwm = (mode_r.md == `MSPP_MD_INTERVAL) && (mode_r.sts == `MSPP_STS_SOFT);
   assign is_oneshot = (mode_r.md == `MSPP_MD_ONE_COUNT);

   always_comb begin
      case ({mode_r.edge_select_hi, mode_r.edge_select_lo})
         `MSPP_CIS_FALL: edge_hit = trig_prev_r & ~trigger_input_pin;
         `MSPP_CIS_RISE: edge_hit = ~trig_prev_r & trigger_input_pin;
         `MSPP_CIS_BOTH: edge_hit = trig_prev_r ^ trigger_input_pin;
         default: edge_hit = 1'b0;
      endcase
      if (mode_r.sts != `MSPP_STS_EDGE) edge_hit = 1'b0;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) trig_prev_r <= 1'b0;
      else trig_prev_r <= trigger_input_pin;
   end

   // ==========================================================
   // master channel
   logic m_fire;
   assign m_fire = tick & master_run_status_r &
                   (((mst_r == mspp_pkg::MST_ARMED) ||
                     ((mst_r == mspp_pkg::MST_COUNT) && (master_count_reg_r == '0))) ||
                    ((mst_r == mspp_pkg::MST_COUNT) && is_oneshot && (master_count_reg_r == '0)));

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mst_r <= mspp_pkg::MST_IDLE;
         master_run_status_r <= 1'b0;
         master_count_reg_r <= '0;
         trig_pend_r <= 1'b0;
         master_done_irq <= 1'b0;
      end else if (unit_off) begin
         mst_r <= mspp_pkg::MST_IDLE;
         master_run_status_r <= 1'b0;
         master_count_reg_r <= '0;
         trig_pend_r <= 1'b0;
         master_done_irq <= 1'b0;
      end else begin
         master_done_irq <= 1'b0;
         // a trigger arriving between ticks waits for the next tick
         if (master_run_status_r && (mst_r == mspp_pkg::MST_WAIT) && (start_m || edge_hit))
            trig_pend_r <= 1'b1;
         if (stop_m) begin
            master_run_status_r <= 1'b0;
            mst_r <= mspp_pkg::MST_IDLE;
            trig_pend_r <= 1'b0;
         end else if (start_m && !master_run_status_r && pair_ok && (is_pwm || is_oneshot)) begin
            master_run_status_r <= 1'b1;
            mst_r <= is_pwm ? mspp_pkg::MST_ARMED : mspp_pkg::MST_WAIT;
         end else if (tick && master_run_status_r) begin
            case (mst_r)
               mspp_pkg::MST_ARMED: begin
                  master_done_irq <= 1'b1;
                  master_count_reg_r <= period_data_reg_r;
                  mst_r <= mspp_pkg::MST_COUNT;
               end
               mspp_pkg::MST_WAIT: begin
                  if (trig_pend_r) begin
                     trig_pend_r <= 1'b0;
                     master_count_reg_r <= period_data_reg_r;
                     mst_r <= mspp_pkg::MST_COUNT;
                  end
               end
               mspp_pkg::MST_COUNT: begin
                  if (master_count_reg_r != '0) begin
                     master_count_reg_r <= master_count_reg_r - 1'b1;
                  end else if (is_oneshot) begin
                     master_done_irq <= 1'b1;
                     mst_r <= mspp_pkg::MST_WAIT;
                  end else begin
                     master_done_irq <= 1'b1;
                     master_count_reg_r <= period_data_reg_r;
                  end
               end
               default: mst_r <= mspp_pkg::MST_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // slave channel and output
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         slave_run_status_r <= 1'b0;
         slave_busy_r <= 1'b0;
         slave_act_r <= 1'b0;
         slave_count_reg_r <= '0;
         slave_done_irq <= 1'b0;
      end else if (unit_off) begin
         slave_run_status_r <= 1'b0;
         slave_busy_r <= 1'b0;
         slave_act_r <= 1'b0;
         slave_count_reg_r <= '0;
         slave_done_irq <= 1'b0;
      end else begin
         slave_done_irq <= 1'b0;
         if (stop_s) begin
            slave_run_status_r <= 1'b0;
         end else if (start_s && start_m && !master_run_status_r && pair_ok) begin
            // slave run set with master; alone it is ignored
            slave_run_status_r <= 1'b1;
         end else if (tick && slave_run_status_r) begin
            if (m_fire) begin
               // level kept across reload, so long duty stays full
               slave_count_reg_r <= duty_data_reg_r;
               slave_busy_r <= 1'b1;
            end else if (slave_busy_r) begin
               if (slave_count_reg_r != '0) begin
                  // active from the tick after the irq
                  slave_count_reg_r <= slave_count_reg_r - 1'b1;
                  slave_act_r <= 1'b1;
               end else begin
                  slave_act_r <= 1'b0;
                  slave_busy_r <= 1'b0;
                  slave_done_irq <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_output_r <= 1'b0;
         pulse_output_enable_r <= 1'b0;
         pulse_polarity_r <= 1'b0;
         pulse_output_mode_r <= 1'b0;
         pulse_pin_o <= 1'b0;
         pulse_pin_oe_n <= 1'b1;
      end else begin
         // port mode while unit is off
         pulse_pin_oe_n <= unit_off;
         pulse_pin_o <= pulse_output_r;
         if (unit_off) begin
            pulse_output_r <= 1'b0;
            pulse_output_enable_r <= 1'b0;
            pulse_polarity_r <= 1'b0;
            pulse_output_mode_r <= 1'b0;
         end else begin
            if (wr_out) begin
               pulse_output_enable_r <= pwdata[1];
               pulse_polarity_r <= pwdata[2];
               pulse_output_mode_r <= pwdata[3];
            end
            if (wr_out && !pulse_output_enable_r) begin
               pulse_output_r <= pwdata[0];
            end else if (pulse_output_enable_r && pulse_output_mode_r && slave_run_status_r) begin
               pulse_output_r <= slave_act_r ^ pulse_polarity_r;
            end
         end
      end
   end

   // ==========================================================
   // assertions
   sequence s_start_pwm;
      start_m && !master_run_status_r && pair_ok && is_pwm && !stop_m;
   endsequence
   sequence s_tick_armed;
      tick && (mst_r == mspp_pkg::MST_ARMED) && master_run_status_r;
   endsequence

   property p_pwm_start;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      s_start_pwm ##1 s_tick_armed |=> master_done_irq && master_count_reg_r == period_data_reg_r;
   endproperty
   a_pwm_start: assert property (p_pwm_start) else $error("start did not load and irq");

   property p_reload;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (tick && master_run_status_r && mst_r == mspp_pkg::MST_COUNT && is_pwm &&
       master_count_reg_r == '0 && !stop_m)
      |=> master_done_irq && master_count_reg_r == $past(period_data_reg_r);
   endproperty
   a_reload: assert property (p_reload) else $error("master did not reload at zero");

   property p_decrement;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (tick && master_run_status_r && mst_r == mspp_pkg::MST_COUNT &&
       master_count_reg_r != '0 && !stop_m)
      |=> master_count_reg_r == $past(master_count_reg_r) - 1'b1;
   endproperty
   a_decrement: assert property (p_decrement) else $error("master count step wrong");

   property p_stop_freeze;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (stop_m && stop_s) |=> !master_run_status_r && !slave_run_status_r &&
         $stable(master_count_reg_r) && $stable(slave_count_reg_r) ##1 $stable(pulse_output_r);
   endproperty
   a_stop_freeze: assert property (p_stop_freeze) else $error("stop did not freeze");

   property p_slave_load;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (m_fire && slave_run_status_r && !stop_s) |=> slave_count_reg_r == $past(duty_data_reg_r);
   endproperty
   a_slave_load: assert property (p_slave_load) else $error("slave did not load duty");

   property p_slave_end;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (tick && slave_run_status_r && slave_busy_r && !m_fire && slave_count_reg_r == '0 && !stop_s)
      |=> slave_done_irq && !slave_act_r && !slave_busy_r;
   endproperty
   a_slave_end: assert property (p_slave_end) else $error("slave end wrong");

   property p_zero_duty;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (m_fire && slave_run_status_r && duty_data_reg_r == '0 && !stop_s && !slave_act_r)
      |=> !slave_act_r [*2];
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("zero duty went active");

   property p_unit_off;
      @(posedge clk_sys) disable iff (sys_rst)
      unit_off |=> !pulse_output_r && pulse_pin_oe_n && !master_run_status_r;
   endproperty
   a_unit_off: assert property (p_unit_off) else $error("unit off did not reset");

   property p_sw_level;
      @(posedge clk_sys) disable iff (sys_rst || unit_off)
      (!pulse_output_enable_r && !wr_out) |=> $stable(pulse_output_r) ##1 pulse_pin_o == $past(pulse_output_r);
   endproperty
   a_sw_level: assert property (p_sw_level) else $error("pin not from software bit");

   property p_trig_zero;
      @(posedge clk_sys) disable iff (sys_rst)
      (psel && penable && !pready && !pwrite && paddr == `MSPP_OFS_TRIGGER) |=> prdata == 32'h0;
   endproperty
   a_trig_zero: assert property (p_trig_zero) else $error("trigger reads nonzero");
endmodule : mspp_top

// file: verification/mspp_trig_model.sv
// external circuit model: edge trigger source feeding the pulse timer
// assumes the bench asks for an edge with fire, one clock wide
`timescale 1ns/1ps
module mspp_trig_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic fire,
   output logic trigger_input_pin
);
   logic [1:0] hold_r;
   // ==========================================
   // trigger pulse
   // line idles low; a request gives two clocks high, so exactly one rising edge
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         hold_r <= 2'h0;
      end else if (fire) begin
         hold_r <= 2'h2;
      end else if (hold_r != 2'h0) begin
         hold_r <= hold_r - 2'h1;
      end
   end
   assign trigger_input_pin = (hold_r != 2'h0);
endmodule : mspp_trig_model

// file: verification/master_slave_pulse_pwm_tb.sv
// self-checking bench of the paired pulse timer, apb master and trigger model
// assumes prescaler exponent 0 gives one count tick per clk_sys
`timescale 1ns/1ps
`include "mspp_defines.svh"
module master_slave_pulse_pwm_tb;
   logic clk_sys, sys_rst, psel, penable, pwrite, fire, pready, pslverr;
   logic pin, oe_n, mirq, sirq, trig, rerr, pin_keep;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, keep;
   int err_count, comparisons;
   mspp_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trigger_input_pin(trig), .pulse_pin_o(pin),
      .pulse_pin_oe_n(oe_n), .master_done_irq(mirq), .slave_done_irq(sirq));
   mspp_trig_model partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire),
      .trigger_input_pin(trig));
   // ==========================================
   // reporting
   task automatic conclude();
      $display("checks %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk
   // ==========================================
   // apb master: request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         err_count++;
         conclude();
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
   endtask : rdchk
   // counts clocks and high pin samples up to and including the next master irq
   task automatic wait_irq(output int gap, output int hi);
      gap = 0;
      hi = 0;
      do begin
         @(posedge clk_sys);
         gap++;
         hi += (pin === 1'b1);
      end while (mirq !== 1'b1 && gap < 300);
      // a missing master event is a mismatch, never a silent pass
      if (mirq !== 1'b1) begin
         err_count++;
         conclude();
      end
   endtask : wait_irq
   task automatic cnt_irq(input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(posedge clk_sys);
         c += (mirq === 1'b1);
      end
   endtask : cnt_irq
   // ==========================================
   // scenarios
   task automatic t_pwm(input int p, input int d, input logic pol, input logic [31:0] cfg,
      input int k);
      int g, h, m;
      // data and mode changed only while stopped
      apb(1'b1, `MSPP_OFS_MODE_CFG, cfg);
      apb(1'b1, `MSPP_OFS_PERIOD, p);
      apb(1'b1, `MSPP_OFS_DUTY, d);
      apb(1'b1, `MSPP_OFS_OUT_CTRL, 32'ha | {29'h0, pol, 2'h0});
      // both start bits in one write
      apb(1'b1, `MSPP_OFS_TRIGGER, 32'h3);
      rdchk("trigger_bits", `MSPP_OFS_TRIGGER, 32'hf, 32'h0);
      wait_irq(g, h);
      wait_irq(g, h);
      wait_irq(g, h);
      m = (d < p + 1) ? d : p + 1;
      chk("period", k * (p + 1), g);
      chk("high_time", pol ? k * (p + 1 - m) : k * m, h);
      apb(1'b0, `MSPP_OFS_MCOUNT, 32'h0);
      chk("mcount_range", 1, rd <= p);
      apb(1'b1, `MSPP_OFS_TRIGGER, 32'hc);
      // output bit and pin lag the stop by two clocks; sample once settled
      repeat (3) @(posedge clk_sys);
      pin_keep = pin;
      rdchk("run_bits_off", `MSPP_OFS_STATUS, 32'h3, 32'h0);
      apb(1'b0, `MSPP_OFS_MCOUNT, 32'h0);
      keep = rd;
      rdchk("mcount_frozen", `MSPP_OFS_MCOUNT, 32'hffff, keep);
      chk("pin_held", pin_keep, pin);
   endtask : t_pwm
   task automatic t_oneshot();
      int c;
      apb(1'b1, `MSPP_OFS_MODE_CFG, 32'h0148);
      apb(1'b1, `MSPP_OFS_PERIOD, 32'h3);
      apb(1'b1, `MSPP_OFS_TRIGGER, 32'h3);
      rdchk("run_bits_on", `MSPP_OFS_STATUS, 32'h3, 32'h3);
      // mode, data and output bits untouched while running
      cnt_irq(20, c);
      chk("no_irq_waiting", 0, c);
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      cnt_irq(30, c);
      chk("edge_irqs", 1, c);
      // only the master start bit is written
      apb(1'b1, `MSPP_OFS_TRIGGER, 32'h1);
      cnt_irq(30, c);
      chk("soft_irqs", 1, c);
      apb(1'b1, `MSPP_OFS_TRIGGER, 32'hc);
   endtask : t_oneshot
   task automatic t_port();
      // the software bit is ignored while the enable is still set
      apb(1'b1, `MSPP_OFS_OUT_CTRL, 32'h0);
      apb(1'b1, `MSPP_OFS_OUT_CTRL, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk("soft_level_hi", 1, pin);
      apb(1'b1, `MSPP_OFS_UNIT_CTRL, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk("pin_released", 2, {oe_n, pin});
      rdchk("period_cleared", `MSPP_OFS_PERIOD, 32'hffff, 32'h0);
   endtask : t_port
   // ==========================================
   // main sequence
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      {psel, penable, pwrite, fire, paddr, pwdata} = '0;
      err_count = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk("reset_pin", 2, {oe_n, pin});
      rdchk("mode_reset", `MSPP_OFS_MODE_CFG, 32'hffff, `MSPP_MODE_CFG_RST);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 1, rerr);
      apb(1'b1, `MSPP_OFS_UNIT_CTRL, 32'h5);
      apb(1'b1, `MSPP_OFS_PRESCALE, 32'h10);
      t_pwm(4, 0, 1'b0, 32'h0, 1);
      t_pwm(4, 2, 1'b0, 32'h0, 1);
      t_pwm(4, 9, 1'b0, 32'h0, 1);
      t_pwm(4, 2, 1'b1, 32'h0, 1);
      t_pwm(3, 1, 1'b0, 32'h8000, 2);
      t_oneshot();
      t_port();
      conclude();
   end
endmodule : master_slave_pulse_pwm_tb
